// ==== rtl/eewc_map.svh ====
// register offsets, field positions and reset values of the edge event controller
// assumes byte addresses on a 32-bit apb bus, one word per register
`ifndef EEWC_MAP_SVH
`define EEWC_MAP_SVH

`define EEWC_OFF_INTMASK  8'h00
`define EEWC_OFF_EVTMASK  8'h04
`define EEWC_OFF_RISE     8'h08
`define EEWC_OFF_FALL     8'h0c
`define EEWC_OFF_PEND     8'h10
`define EEWC_OFF_SEL0     8'h14
`define EEWC_OFF_SEL1     8'h18
`define EEWC_OFF_SEL2     8'h1c
`define EEWC_OFF_SEL3     8'h20
`define EEWC_OFF_STAT     8'h24
`define EEWC_OFF_STATMASK 8'h28

// each select register holds four 8-bit fields, pin index in the low 7 bits
`define EEWC_SEL_FIELD_W  8
`define EEWC_SEL_PER_REG  4
`define EEWC_RST_WORD     32'h0000_0000
`define EEWC_RST_SEL      7'h00

`endif

// ==== rtl/eewc_pkg.sv ====
// types shared by the edge event controller modules
// assumes nothing beyond a sv-2012 compiler
`default_nettype none
package eewc_pkg;
  typedef logic [31:0] eewc_word_t;
  typedef logic [6:0]  eewc_pinsel_t;
  typedef logic [7:0]  eewc_addr_t;
endpackage
`default_nettype wire

// ==== rtl/eewc_edge_cell.sv ====
// one edge detector line: asynchronous capture, then sync into clk
// assumes riseEn/fallEn are quasi-static registers of the clk domain
`default_nettype none
module eewc_edge_cell (
  // system
  input  wire logic clk,
  input  wire logic reset,
  // line
  input  wire logic lineIn,
  input  wire logic riseEn,
  input  wire logic fallEn,
  // result
  output logic      edgeSeen
);
  logic riseCap;
  logic fallCap;
  logic clrReq;
  logic syncA;
  logic syncB;
  logic syncC;
  logic capClr;

  assign capClr = reset | clrReq;

  // the input itself clocks the capture so pulses shorter than clk survive
  always_ff @(posedge lineIn or posedge capClr) begin
    if (capClr) begin
      riseCap <= 1'b0;
    end else begin
      riseCap <= riseEn;
    end
  end

  always_ff @(negedge lineIn or posedge capClr) begin
    if (capClr) begin
      fallCap <= 1'b0;
    end else begin
      fallCap <= fallEn;
    end
  end

  // limitation: an edge during the clear handshake (about 3 clocks) is lost
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      syncA    <= 1'b0;
      syncB    <= 1'b0;
      syncC    <= 1'b0;
      clrReq   <= 1'b0;
      edgeSeen <= 1'b0;
    end else begin
      syncA    <= riseCap | fallCap;
      syncB    <= syncA;
      syncC    <= syncB;
      clrReq   <= syncB;
      edgeSeen <= syncB & ~syncC;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/eewc_pin_mux.sv ====
// routes one of the general-purpose pins onto each external line
// combinational on purpose: capture downstream must see raw pin edges
`default_nettype none
module eewc_pin_mux #(
  parameter int PINS  = 88,
  parameter int LINES = 16
) (
  // pins
  input  wire logic [PINS-1:0]    pins,
  // one 7-bit select per line
  input  wire logic [LINES*7-1:0] selFlat,
  // lines
  output logic [LINES-1:0]        lineOut
);
  for (genvar i = 0; i < LINES; i++) begin : g_line
    logic [6:0] sel;
    assign sel = selFlat[i*7 +: 7];
    // out-of-range selects read as a quiet low line
    assign lineOut[i] = (32'(sel) < PINS) ? pins[sel] : 1'b0;
  end
endmodule
`default_nettype wire

// ==== rtl/eewc_controller.sv ====
// edge event controller: 32 edge lines, apb register file, requests out
// assumes apb master on clk; pins and internal sources are asynchronous
//
// Summary of operation
// - 32 lines raise interrupt, event, wakeup requests
// - per-line rising, falling or both edges
// - per-line mask blocks only that line
// - pending bit latches detected edge for software
// - pulses shorter than clock still captured
// - 16 external lines select from 88 pins
// - event-mode line wakes system from sleep only while clk keeps running
`include "eewc_map.svh"
`default_nettype none
module eewc_controller
  import eewc_pkg::*;
#(
  parameter int LINES     = 32,
  parameter int EXT_LINES = 16,
  parameter int PINS      = 88
) (
  // system
  input  wire logic                       clk,
  input  wire logic                       reset,
  // apb slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [7:0]                 paddr,
  input  wire logic [31:0]                pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // sources
  input  wire logic [PINS-1:0]            gpioPins,
  input  wire logic [LINES-EXT_LINES-1:0] internalSrc,
  // requests to the processor
  output logic      [LINES-1:0]           irqReq,
  output logic      [LINES-1:0]           eventPulse,
  output logic                            wakeupReq,
  output logic                            irq
);
  eewc_word_t   intMask;
  eewc_word_t   evtMask;
  eewc_word_t   riseSel;
  eewc_word_t   fallSel;
  eewc_word_t   pending;
  eewc_word_t   evStat;
  eewc_word_t   statMask;
  eewc_pinsel_t pinSel [EXT_LINES];

  logic [EXT_LINES*7-1:0] selFlat;
  logic [EXT_LINES-1:0]   extLines;
  logic [LINES-1:0]       lineIn;
  logic [LINES-1:0]       edgeSeen;
  eewc_word_t             edgeWord;

  logic       setupPhase;
  logic       accessPhase;
  logic       mapped;
  logic       wrDone;
  logic       rdDone;
  eewc_word_t rdMux;
  eewc_word_t wrMask;
  eewc_word_t next_pending;
  eewc_word_t next_evStat;

  // pin routing onto the external lines

  for (genvar i = 0; i < EXT_LINES; i++) begin : g_sel
    assign selFlat[i*7 +: 7] = pinSel[i];
  end

  eewc_pin_mux #(
    .PINS  (PINS),
    .LINES (EXT_LINES)
  ) u_pin_mux (
    .pins    (gpioPins),
    .selFlat (selFlat),
    .lineOut (extLines)
  );

  assign lineIn = {internalSrc, extLines};

  // one capture cell per line

  for (genvar i = 0; i < LINES; i++) begin : g_cell
    eewc_edge_cell u_cell (
      .clk      (clk),
      .reset    (reset),
      .lineIn   (lineIn[i]),
      .riseEn   (riseSel[i]),
      .fallEn   (fallSel[i]),
      .edgeSeen (edgeSeen[i])
    );
  end

  assign edgeWord = 32'(edgeSeen);

  // apb decode

  assign setupPhase  = psel & ~penable;
  assign accessPhase = psel & penable;

  always_comb begin
    mapped = 1'b1;
    rdMux  = `EEWC_RST_WORD;
    unique case (paddr)
      `EEWC_OFF_INTMASK:  rdMux = intMask;
      `EEWC_OFF_EVTMASK:  rdMux = evtMask;
      `EEWC_OFF_RISE:     rdMux = riseSel;
      `EEWC_OFF_FALL:     rdMux = fallSel;
      `EEWC_OFF_PEND:     rdMux = pending;
      `EEWC_OFF_SEL0:     rdMux = {1'b0, pinSel[3], 1'b0, pinSel[2], 1'b0, pinSel[1], 1'b0, pinSel[0]};
      `EEWC_OFF_SEL1:     rdMux = {1'b0, pinSel[7], 1'b0, pinSel[6], 1'b0, pinSel[5], 1'b0, pinSel[4]};
      `EEWC_OFF_SEL2:     rdMux = {1'b0, pinSel[11], 1'b0, pinSel[10], 1'b0, pinSel[9], 1'b0, pinSel[8]};
      `EEWC_OFF_SEL3:     rdMux = {1'b0, pinSel[15], 1'b0, pinSel[14], 1'b0, pinSel[13], 1'b0, pinSel[12]};
      `EEWC_OFF_STAT:     rdMux = evStat;
      `EEWC_OFF_STATMASK: rdMux = statMask;
      default:            mapped = 1'b0;
    endcase
  end

  // read data is registered in setup, so every access takes exactly one access cycle
  assign pready  = accessPhase;
  assign pslverr = accessPhase & ~mapped;
  assign wrDone  = accessPhase & pwrite & mapped;
  assign rdDone  = accessPhase & ~pwrite & mapped;

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wrMask[b*8 +: 8] = {8{pstrb[b]}};
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prdata <= `EEWC_RST_WORD;
    end else if (setupPhase) begin
      prdata <= pwrite ? `EEWC_RST_WORD : rdMux;
    end
  end

  // configuration registers

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      intMask  <= `EEWC_RST_WORD;
      evtMask  <= `EEWC_RST_WORD;
      riseSel  <= `EEWC_RST_WORD;
      fallSel  <= `EEWC_RST_WORD;
      statMask <= `EEWC_RST_WORD;
    end else if (wrDone) begin
      unique case (paddr)
        `EEWC_OFF_INTMASK:  intMask  <= (intMask & ~wrMask) | (pwdata & wrMask);
        `EEWC_OFF_EVTMASK:  evtMask  <= (evtMask & ~wrMask) | (pwdata & wrMask);
        `EEWC_OFF_RISE:     riseSel  <= (riseSel & ~wrMask) | (pwdata & wrMask);
        `EEWC_OFF_FALL:     fallSel  <= (fallSel & ~wrMask) | (pwdata & wrMask);
        `EEWC_OFF_STATMASK: statMask <= (statMask & ~wrMask) | (pwdata & wrMask);
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < EXT_LINES; i++) begin
        pinSel[i] <= `EEWC_RST_SEL;
      end
    end else if (wrDone) begin
      for (int i = 0; i < EXT_LINES; i++) begin
        if (paddr == `EEWC_OFF_SEL0 + 8'(4 * (i / `EEWC_SEL_PER_REG)) &&
            pstrb[i % `EEWC_SEL_PER_REG]) begin
          pinSel[i] <= pwdata[(i % `EEWC_SEL_PER_REG) * `EEWC_SEL_FIELD_W +: 7];
        end
      end
    end
  end

  // pending: set by an unmasked edge, cleared by writing one; set wins

  always_comb begin
    next_pending = pending;
    if (wrDone && paddr == `EEWC_OFF_PEND) begin
      next_pending = pending & ~(pwdata & wrMask);
    end
    next_pending = next_pending | (edgeWord & intMask);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pending <= `EEWC_RST_WORD;
    end else begin
      pending <= next_pending;
    end
  end

  // status: any detected edge; a read clears only the bits it returned,
  // so an edge landing between setup and access is kept
  always_comb begin
    next_evStat = evStat;
    if (rdDone && paddr == `EEWC_OFF_STAT) begin
      next_evStat = evStat & ~prdata;
    end
    next_evStat = next_evStat | edgeWord;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      evStat <= `EEWC_RST_WORD;
    end else begin
      evStat <= next_evStat;
    end
  end

  // requests toward the processor

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irqReq     <= '0;
      eventPulse <= '0;
      wakeupReq  <= 1'b0;
      irq        <= 1'b0;
    end else begin
      irqReq     <= LINES'(next_pending & intMask);
      eventPulse <= LINES'(edgeWord & evtMask);
      // sleep exit needs a running clk; capture itself needs none
      wakeupReq  <= |(edgeWord & evtMask);
      irq        <= |(next_evStat & statMask);
    end
  end
endmodule
`default_nettype wire

// ==== dv/eewc_assertions.sv ====
// port checker of the edge event controller
// assumes one clk domain, apb without wait states
`default_nettype none
module eewc_assertions #(
  parameter int LINES = 32
) (
  // system
  input wire logic             clk,
  input wire logic             reset,
  // apb
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [7:0]       paddr,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic             pslverr,
  // requests
  input wire logic [LINES-1:0] irqReq,
  input wire logic [LINES-1:0] eventPulse,
  input wire logic             wakeupReq,
  input wire logic             irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic acc;
  logic wacc;
  assign acc = psel && penable;
  assign wacc = acc && pwrite;
  ready_follows_a: assert property (pready == acc) else $error("pready wrong");
  err_misalign_a: assert property (acc && paddr[1:0] != 0 |-> pslverr) else $error("no err");
  err_mapped_a: assert property (acc && paddr[1:0] == 0 && paddr <= 8'h28 |-> !pslverr) else $error("err");
  err_data_a: assert property (pslverr |-> acc && prdata == 0) else $error("err data");
  write_data_a: assert property (wacc |-> prdata == 0) else $error("write data");
  wake_any_a: assert property (wakeupReq == |eventPulse) else $error("wakeup wrong");
  evt_single_a: assert property (|eventPulse |=> (eventPulse & $past(eventPulse)) == 0)
    else $error("long event");
  irq_clear_a: assert property (|($past(irqReq) & ~irqReq) |-> $past(wacc) || $past(wacc, 2) || $past(wacc, 3))
    else $error("request dropped");
  cover property (wakeupReq);
  cover property (pslverr);
  cover property ($fell(irq));
endmodule
bind eewc_controller eewc_assertions #(.LINES(LINES)) uChk (.clk(clk), .reset(reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .irqReq(irqReq), .eventPulse(eventPulse), .wakeupReq(wakeupReq), .irq(irq));
`default_nettype wire

// ==== dv/eewc_core_model.sv ====
// processor side: counts event and wakeup requests
// assumes requests are clk pulses
`default_nettype none
module eewc_core_model (
  // system
  input  wire logic        clk,
  input  wire logic        reset,
  // requests
  input  wire logic [31:0] eventPulse,
  input  wire logic        wakeupReq,
  // counts
  output var  int          evCount,
  output var  int          wakeCount
);
  timeunit 1ns;
  timeprecision 1ns;
  // one pulse is one wakeup, so a stuck level shows as a surplus
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      evCount <= 0;
      wakeCount <= 0;
    end else begin
      evCount <= evCount + $countones(eventPulse);
      wakeCount <= wakeCount + int'(wakeupReq);
    end
  end
endmodule
`default_nettype wire

// ==== dv/eewc_controller_tb.sv ====
// bench of the edge event controller with a bit model
// assumes the map header and no apb wait states
`include "eewc_map.svh"
`default_nettype none
module eewc_controller_tb;
  import eewc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic        pready, pslverr, wakeupReq, irq, err;
  eewc_addr_t  paddr = 0;
  eewc_word_t  pwdata = 0, prdata, rd, irqReq, eventPulse;
  eewc_word_t  mPend = 0, mStat = 0, mRise, mFall, mInt, mEvt;
  logic [87:0] gpioPins = 0;
  logic [15:0] internalSrc = 0;
  logic [31:0] seed = 32'h5f;
  int          n_fail = 0, cmp_count = 0, nEv = 0, evCount, wakeCount, p;
  always #50 clk = ~clk;
  eewc_controller dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .gpioPins(gpioPins), .internalSrc(internalSrc), .irqReq(irqReq), .eventPulse(eventPulse),
    .wakeupReq(wakeupReq), .irq(irq));
  eewc_core_model core (.clk(clk), .reset(reset), .eventPulse(eventPulse), .wakeupReq(wakeupReq),
    .evCount(evCount), .wakeCount(wakeCount));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input eewc_addr_t a, input eewc_word_t d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // edges spaced 9 clocks, beyond the lost-edge window
  task automatic tog(input int l, input logic v);
    @(posedge clk);
    internalSrc[l-16] <= v;
    if (v ? mRise[l] : mFall[l]) begin
      mStat[l] = 1;
      mPend[l] = mPend[l] | mInt[l];
      nEv += int'(mEvt[l]);
    end
    repeat (8) @(posedge clk);
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #200us;
    n_fail++;
    report_and_stop();
  end
  initial begin
    p = int'(xs() % 88);
    repeat (20) @(posedge clk);
    reset <= 0;
    for (int a = 0; a <= 'h28; a += 4) begin
      apb(0, a[7:0], 0);
      chk("reset value", 0, rd);
    end
    apb(0, 8'h2c, 0);
    chk("unmapped", 1, err);
    $display("test reset done");
    mInt = 32'hfff7_ffff;
    mRise = 32'h000d_0001;
    mFall = 32'h0006_0000;
    // line 18 has both edges but no event: proves the event mask per line
    mEvt = 32'hfffb_ffff;
    apb(1, `EEWC_OFF_INTMASK, mInt);
    apb(1, `EEWC_OFF_EVTMASK, mEvt);
    apb(1, `EEWC_OFF_RISE, mRise);
    apb(1, `EEWC_OFF_FALL, mFall);
    apb(1, `EEWC_OFF_SEL0, 32'(p));
    apb(1, `EEWC_OFF_STATMASK, 32'h0001_0000);
    for (int l = 16; l < 20; l++) tog(l, 1);
    for (int l = 16; l < 20; l++) tog(l, 0);
    @(posedge clk);
    gpioPins[p] <= 1;
    #(10 + xs() % 60) gpioPins[p] <= 0;
    mStat[0] = 1;
    mPend[0] = 1;
    nEv++;
    repeat (8) @(posedge clk);
    chk("irq", 1, irq);
    chk("irq req", mPend & mInt, irqReq);
    apb(0, `EEWC_OFF_PEND, 0);
    chk("pending", mPend, rd);
    apb(0, `EEWC_OFF_STAT, 0);
    chk("status", mStat, rd);
    repeat (3) @(posedge clk);
    chk("irq off", 0, irq);
    chk("events", nEv, evCount);
    chk("wakeups", nEv, wakeCount);
    apb(1, `EEWC_OFF_PEND, 0);
    apb(0, `EEWC_OFF_PEND, 0);
    chk("write zero", mPend, rd);
    apb(1, `EEWC_OFF_PEND, mPend);
    apb(0, `EEWC_OFF_PEND, 0);
    chk("write one", 0, rd);
    repeat (3) @(posedge clk);
    chk("irq req off", 0, irqReq);
    $display("test edges done");
    report_and_stop();
  end
endmodule
`default_nettype wire
